//--- logic/lsw_defs.vh
// Constants of the wake and mode controller: mode codes, wake detector states,
// synchroniser reset pattern and timing figures.
// Assumes the including module runs on a 10 MHz system clock.
`ifndef LSW_DEFS_VH
`define LSW_DEFS_VH

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define LSW_MODE_UNPOWERED 3'h0
`define LSW_MODE_FAILSAFE 3'h1
`define LSW_MODE_NORMAL 3'h2
`define LSW_MODE_SILENT 3'h3
`define LSW_MODE_SLEEP 3'h4

// ----------------------------------------------------------------------
// Bus wake detector states
// ----------------------------------------------------------------------
`define LSW_WK_IDLE 2'h0
`define LSW_WK_DOM 2'h1
`define LSW_WK_LONG 2'h2

// ----------------------------------------------------------------------
// Input vector layout and reset pattern
// ----------------------------------------------------------------------
`define LSW_IN_EN 0
`define LSW_IN_TXD 1
`define LSW_IN_BUS 2
`define LSW_IN_PREWAKE 3
`define LSW_IN_BAT_OP 4
`define LSW_IN_BAT_UV 5
`define LSW_IN_VCC_UV 6
`define LSW_IN_OT 7
`define LSW_IN_W 8
`define LSW_SYNC_RST 8'h66

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Host reset delay, 4 ms at the 10 MHz clock
`define LSW_RES_CYC 17'h09C40
// Dominant time that qualifies a bus wake, 100 us at the 10 MHz clock
`define LSW_DOM_CYC 11'h3E8

`endif

//--- logic/lsw_mode_ctrl.v
// Mode and wake-up controller of a bus system basis chip: unpowered, fail-safe,
// normal, silent and sleep modes, bus wake detection and host reset output.
// Assumes all inputs are asynchronous levels from pins or analog comparators.
// What this block does
// - Silent mode accepts bus wake only while transmit pin is high.
// - Bus below pre-wake threshold in low power enables receiver, starts wake timer.
// - Wake needs falling edge, dominant longer than wake time, then rising edge.
// - Silent bus wake enters fail-safe, regulator stays on, termination reconnected.
// - After bus wake, receive pin low and transmit pin pulled strongly low.
// - After silent wake, host raising enable goes straight to normal.
// - Sleep bus wake enters fail-safe, regulator on, termination reconnected.
// - Enable high in sleep/silent gives fail-safe, then normal; after ramp and delay from sleep, with no delay from silent.
// - Wake-source indication clears when enable high reaches normal mode.
// - Fail-safe coding: bus wake low/low, battery undervoltage high/low.
// - Supply above operating threshold leaves unpowered; transceiver needs no undervoltage.
// - Reset output low for reset delay; no mode change until it elapses.
// - Sleep with battery undervoltage keeps mode and blocks all wake-ups.
// - Sleep or silent with supply below operating threshold goes unpowered.
// - Silent with regulator undervoltage moves to fail-safe.
// - Normal with battery undervoltage: fail-safe, transceiver off, regulator on.
// - Fail-safe entered by normal undervoltage honours falling enable to low power.
// - Regulator undervoltage in any mode except sleep forces fail-safe.
// - Regulator undervoltage drives host reset low.
// - Over-temperature switches regulator off; back on when indication clears.
// - Fail-safe waits for enable high, then goes to normal.
// - Enable falling with transmit high gives silent, regulator active.
// - Enable falling with transmit low gives sleep, regulator off, reset and receive low.
// - Power-up enters fail-safe with reset low for the power-up reset time.
`include "lsw_defs.vh"

module lsw_mode_ctrl #(
  parameter [16:0] RES_CYC = `LSW_RES_CYC
) (
  input wire sys_clk,
  input wire resetn,
  input wire en_pin,
  input wire txd_in,
  output wire txd_out,
  output wire txd_oe,
  output wire rxd_out,
  input wire bus_in,
  input wire bus_prewake_threshold,
  input wire battery_supply_op,
  input wire battery_supply_uv,
  input wire vcc_uv,
  input wire regulator_overtemp_limit,
  output wire host_reset_out_n,
  output wire regulator_on,
  output wire transceiver_en,
  output wire termination_on,
  output wire bus_rx_en,
  output wire bus_drive_dom,
  output wire [2:0] mode_out
);
  localparam [10:0] DOM_CYC = `LSW_DOM_CYC;

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  wire [`LSW_IN_W-1:0] raw_in;
  wire [`LSW_IN_W-1:0] syn_in;
  assign raw_in = {regulator_overtemp_limit, vcc_uv, battery_supply_uv,
                   battery_supply_op, bus_prewake_threshold, bus_in, txd_in, en_pin};
  lsw_sync #(
    .W(`LSW_IN_W),
    .RST_VAL(`LSW_SYNC_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d(raw_in),
    .q(syn_in)
  );

  wire en_s = syn_in[`LSW_IN_EN];
  wire txd_s = syn_in[`LSW_IN_TXD];
  wire bus_s = syn_in[`LSW_IN_BUS];
  wire prewake_s = syn_in[`LSW_IN_PREWAKE];
  wire bat_op_s = syn_in[`LSW_IN_BAT_OP];
  wire bat_uv_s = syn_in[`LSW_IN_BAT_UV];
  wire vcc_uv_s = syn_in[`LSW_IN_VCC_UV];
  wire ot_s = syn_in[`LSW_IN_OT];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [2:0] mode_r;
  reg [2:0] mode_nxt;
  reg src_wake_r;
  reg src_wake_nxt;
  reg src_uv_r;
  reg src_uv_nxt;
  reg uv_from_normal_r;
  reg uv_from_normal_nxt;
  reg rst_clr;
  reg [16:0] rst_cnt_r;
  reg en_prev_r;
  reg bus_prev_r;
  reg [1:0] wk_r;
  reg [1:0] wk_nxt;
  reg [10:0] dom_cnt_r;
  reg [10:0] dom_cnt_nxt;
  reg txd_out_r;
  reg txd_oe_r;
  reg rxd_out_r;
  reg host_reset_n_r;
  reg regulator_on_r;
  reg transceiver_en_r;
  reg termination_on_r;
  reg bus_rx_en_r;
  reg bus_drive_dom_r;
  wire en_fall = en_prev_r & ~en_s;
  wire bus_fall = bus_prev_r & ~bus_s;
  wire rst_busy = (rst_cnt_r != RES_CYC);

  function is_low_power;
    input [2:0] m;
    begin
      is_low_power = (m == `LSW_MODE_SLEEP) || (m == `LSW_MODE_SILENT);
    end
  endfunction

  function [2:0] low_power_pick;
    input txd_high;
    begin
      if (txd_high)
        low_power_pick = `LSW_MODE_SILENT;
      else
        low_power_pick = `LSW_MODE_SLEEP;
    end
  endfunction

  // Bus wake is only armed where the mode lets it count
  wire wake_allowed = ((mode_r == `LSW_MODE_SILENT) && txd_s) ||
                      ((mode_r == `LSW_MODE_SLEEP) && !bat_uv_s);
  wire wake_hit = (wk_r == `LSW_WK_LONG) && bus_s && wake_allowed;

  // ----------------------------------------------------------------------
  // Bus wake detector
  // ----------------------------------------------------------------------
  always @*
  begin
    wk_nxt = wk_r;
    dom_cnt_nxt = dom_cnt_r;
    if (!wake_allowed)
    begin
      wk_nxt = `LSW_WK_IDLE;
      dom_cnt_nxt = 11'h000;
    end
    else
    begin
      case (wk_r)
        `LSW_WK_IDLE:
        begin
          dom_cnt_nxt = 11'h000;
          if (prewake_s && bus_fall)
            wk_nxt = `LSW_WK_DOM;
        end
        `LSW_WK_DOM:
        begin
          if (bus_s)
            wk_nxt = `LSW_WK_IDLE;
          else if (dom_cnt_r == DOM_CYC)
            wk_nxt = `LSW_WK_LONG;
          else
            dom_cnt_nxt = dom_cnt_r + 11'h001;
        end
        `LSW_WK_LONG:
          if (bus_s)
            wk_nxt = `LSW_WK_IDLE;
        default:
          wk_nxt = `LSW_WK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------------
  always @*
  begin
    mode_nxt = mode_r;
    src_wake_nxt = src_wake_r;
    src_uv_nxt = src_uv_r;
    uv_from_normal_nxt = uv_from_normal_r;
    rst_clr = 1'b0;
    if (!bat_op_s)
    begin
      // Losing the supply outranks everything else
      mode_nxt = `LSW_MODE_UNPOWERED;
      src_wake_nxt = 1'b0;
      src_uv_nxt = 1'b0;
      uv_from_normal_nxt = 1'b0;
      rst_clr = 1'b1;
    end
    else
    begin
      case (mode_r)
        `LSW_MODE_UNPOWERED:
        begin
          mode_nxt = `LSW_MODE_FAILSAFE;
          rst_clr = 1'b1;
        end
        `LSW_MODE_SLEEP:
        begin
          // Regulator is off here, so its undervoltage is expected and ignored
          if (!bat_uv_s)
          begin
            if (wake_hit)
            begin
              mode_nxt = `LSW_MODE_FAILSAFE;
              src_wake_nxt = 1'b1;
              rst_clr = 1'b1;
            end
            else if (en_s)
            begin
              mode_nxt = `LSW_MODE_FAILSAFE;
              rst_clr = 1'b1;
            end
          end
        end
        `LSW_MODE_SILENT:
        begin
          if (vcc_uv_s)
            mode_nxt = `LSW_MODE_FAILSAFE;
          else if (wake_hit)
          begin
            mode_nxt = `LSW_MODE_FAILSAFE;
            src_wake_nxt = 1'b1;
          end
          else if (en_s)
            mode_nxt = `LSW_MODE_FAILSAFE;
        end
        `LSW_MODE_NORMAL:
        begin
          if (vcc_uv_s)
            mode_nxt = `LSW_MODE_FAILSAFE;
          else if (bat_uv_s)
          begin
            mode_nxt = `LSW_MODE_FAILSAFE;
            src_uv_nxt = 1'b1;
            uv_from_normal_nxt = 1'b1;
          end
          else if (en_fall)
          begin
            mode_nxt = low_power_pick(txd_s);
            rst_clr = !txd_s;
          end
        end
        `LSW_MODE_FAILSAFE:
        begin
          if (!rst_busy)
          begin
            if (uv_from_normal_r && en_fall)
            begin
              mode_nxt = low_power_pick(txd_s);
              rst_clr = !txd_s;
              uv_from_normal_nxt = 1'b0;
            end
            else if (en_s && !bat_uv_s)
            begin
              mode_nxt = `LSW_MODE_NORMAL;
              src_wake_nxt = 1'b0;
              src_uv_nxt = 1'b0;
              uv_from_normal_nxt = 1'b0;
            end
          end
        end
        default:
        begin
          mode_nxt = `LSW_MODE_UNPOWERED;
          rst_clr = 1'b1;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r <= `LSW_MODE_UNPOWERED;
      src_wake_r <= 1'b0;
      src_uv_r <= 1'b0;
      uv_from_normal_r <= 1'b0;
      en_prev_r <= 1'b0;
      bus_prev_r <= 1'b1;
      wk_r <= `LSW_WK_IDLE;
      dom_cnt_r <= 11'h000;
    end
    else
    begin
      mode_r <= mode_nxt;
      src_wake_r <= src_wake_nxt;
      src_uv_r <= src_uv_nxt;
      uv_from_normal_r <= uv_from_normal_nxt;
      en_prev_r <= en_s;
      bus_prev_r <= bus_s;
      wk_r <= wk_nxt;
      dom_cnt_r <= dom_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Reset delay
  // ----------------------------------------------------------------------
  // Counts only with a healthy regulator, so ramp-up time adds to the delay
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rst_cnt_r <= 17'h00000;
    else if (rst_clr || vcc_uv_s || !regulator_on_r)
      rst_cnt_r <= 17'h00000;
    else if (rst_busy)
      rst_cnt_r <= rst_cnt_r + 17'h00001;
  end

  // ----------------------------------------------------------------------
  // Registered pin and control outputs
  // ----------------------------------------------------------------------
  wire fs_mode = (mode_r == `LSW_MODE_FAILSAFE);
  wire nm_mode = (mode_r == `LSW_MODE_NORMAL);
  wire sl_mode = (mode_r == `LSW_MODE_SILENT);
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txd_out_r <= 1'b1;
      txd_oe_r <= 1'b0;
      rxd_out_r <= 1'b0;
      host_reset_n_r <= 1'b0;
      regulator_on_r <= 1'b0;
      transceiver_en_r <= 1'b0;
      termination_on_r <= 1'b0;
      bus_rx_en_r <= 1'b0;
      bus_drive_dom_r <= 1'b0;
    end
    else
    begin
      // Temperature shutdown overrides every mode; the comparator supplies hysteresis
      regulator_on_r <= (fs_mode || nm_mode || sl_mode) && !ot_s;
      transceiver_en_r <= nm_mode && !bat_uv_s;
      termination_on_r <= fs_mode || nm_mode;
      bus_rx_en_r <= nm_mode || (is_low_power(mode_r) && prewake_s);
      bus_drive_dom_r <= nm_mode && !bat_uv_s && !txd_s;
      host_reset_n_r <= !rst_busy && !vcc_uv_s && regulator_on_r;
      txd_oe_r <= fs_mode;
      txd_out_r <= !src_wake_r;
      if (fs_mode)
        rxd_out_r <= !(src_wake_r || src_uv_r);
      else if (nm_mode)
        rxd_out_r <= bus_s;
      else
        rxd_out_r <= sl_mode;
    end
  end

  assign txd_out = txd_out_r;
  assign txd_oe = txd_oe_r;
  assign rxd_out = rxd_out_r;
  assign host_reset_out_n = host_reset_n_r;
  assign regulator_on = regulator_on_r;
  assign transceiver_en = transceiver_en_r;
  assign termination_on = termination_on_r;
  assign bus_rx_en = bus_rx_en_r;
  assign bus_drive_dom = bus_drive_dom_r;
  assign mode_out = mode_r;
endmodule // lsw_mode_ctrl

//--- logic/lsw_sync.v
// Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes asynchronous pin levels; output moves only when stages two and three agree.
module lsw_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire sys_clk,
  input wire resetn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;

  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_lane
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg q_r;
      // First stage feeds only the second
      always @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1_r <= RST_VAL[i];
          s2_r <= RST_VAL[i];
          s3_r <= RST_VAL[i];
          q_r <= RST_VAL[i];
        end
        else
        begin
          s1_r <= d[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r)
            q_r <= s3_r;
        end
      end
      assign q[i] = q_r;
    end
  endgenerate

endmodule // lsw_sync

//--- verif/lsw_host_model.sv
// Far side of the mode controller: host transmit pin and the bus line.
// Assumes the bench commands the host level and bus dominance at the falling edge.
module lsw_host_model (
  input wire host_txd,
  input wire bus_dom,
  input wire txd_out,
  input wire txd_oe,
  output wire txd_in,
  output wire bus_in,
  output wire bus_prewake_threshold
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device drive wins over the host's weak level while txd_oe is set, that is throughout fail-safe mode
  assign txd_in = txd_oe ? txd_out : host_txd;
  // Recessive by pull-up when nobody pulls the bus down
  assign bus_in = !bus_dom;
  assign bus_prewake_threshold = bus_dom;
endmodule // lsw_host_model

//--- verif/lsw_mode_ctrl_checker.sv
// Concurrent checks on the ports of the mode controller.
// Assumes input synchroniser latency below six edges; bound to the top module.
`include "lsw_defs.vh"
module lsw_mode_ctrl_checker #(
  parameter int RES_CYC = 40000
) (
  input wire sys_clk,
  input wire resetn,
  input wire battery_supply_op,
  input wire vcc_uv,
  input wire regulator_overtemp_limit,
  input wire txd_out,
  input wire txd_oe,
  input wire rxd_out,
  input wire host_reset_out_n,
  input wire regulator_on,
  input wire transceiver_en,
  input wire termination_on,
  input wire bus_drive_dom,
  input wire [2:0] mode_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Raw vcc_uv leads the synced copy, so this count never trails the design's
  logic [17:0] ok_cnt_r;
  logic [17:0] ok_cnt_nxt;
  always_comb
  begin
    ok_cnt_nxt = ok_cnt_r;
    if (!regulator_on || vcc_uv)
      ok_cnt_nxt = 18'h0;
    else if (!ok_cnt_r[17])
      ok_cnt_nxt = ok_cnt_r + 18'h1;
  end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ok_cnt_r <= 18'h0;
    else
      ok_cnt_r <= ok_cnt_nxt;
  end
  AST_SLEEP_OUT: assert property (
    (mode_out == `LSW_MODE_SLEEP) [*4] |-> !regulator_on && !host_reset_out_n && !rxd_out)
    else $error("Sleep mode outputs not in low-power state");
  AST_SILENT_OUT: assert property (
    (mode_out == `LSW_MODE_SILENT && !regulator_overtemp_limit) [*6]
    |-> regulator_on && rxd_out && !transceiver_en)
    else $error("Silent mode outputs wrong");
  AST_FS_NO_TX: assert property (
    $past(mode_out) == `LSW_MODE_FAILSAFE && mode_out == `LSW_MODE_FAILSAFE
    |-> !transceiver_en && !bus_drive_dom && termination_on)
    else $error("Fail-safe mode transmits or lacks termination");
  AST_UNPOWERED: assert property (
    (!battery_supply_op) [*8] |-> mode_out == `LSW_MODE_UNPOWERED)
    else $error("Supply loss did not reach unpowered mode");
  AST_VCC_UV_FS: assert property (
    (battery_supply_op && vcc_uv) [*8]
    |-> mode_out == `LSW_MODE_FAILSAFE || mode_out == `LSW_MODE_SLEEP)
    else $error("Regulator undervoltage did not force fail-safe");
  AST_VCC_UV_RST: assert property (
    vcc_uv [*8] |-> !host_reset_out_n)
    else $error("Host reset high during regulator undervoltage");
  AST_RST_DELAY: assert property (
    $rose(host_reset_out_n) |-> ok_cnt_r >= RES_CYC)
    else $error("Host reset released before the reset delay");
  AST_TXD_DRIVE: assert property (
    (mode_out != `LSW_MODE_FAILSAFE) [*2] |-> !txd_oe)
    else $error("Transmit pin driven outside fail-safe mode");
  AST_WAKE_CODE: assert property (
    txd_oe && !txd_out |-> !rxd_out)
    else $error("Bus wake source coded wrongly on receive pin");
  COV_SLEEP: cover property (mode_out == `LSW_MODE_SLEEP);
  COV_BUS_WAKE: cover property (txd_oe && !txd_out);
  COV_RST_RISE: cover property ($rose(host_reset_out_n));
endmodule // lsw_mode_ctrl_checker

bind lsw_mode_ctrl lsw_mode_ctrl_checker #(.RES_CYC(RES_CYC)) u_lsw_chk (
  .sys_clk(sys_clk), .resetn(resetn), .battery_supply_op(battery_supply_op),
  .vcc_uv(vcc_uv), .regulator_overtemp_limit(regulator_overtemp_limit),
  .txd_out(txd_out), .txd_oe(txd_oe), .rxd_out(rxd_out),
  .host_reset_out_n(host_reset_out_n), .regulator_on(regulator_on),
  .transceiver_en(transceiver_en), .termination_on(termination_on),
  .bus_drive_dom(bus_drive_dom), .mode_out(mode_out)
);

//--- verif/test_lsw_mode_ctrl.sv
// Self-checking bench of the mode controller with host and bus model.
// Assumes a 10 MHz clock and a shortened reset delay of RC cycles.
`include "lsw_defs.vh"
module test_lsw_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [16:0] RC = 17'h14;
  localparam logic [2:0] m_unp = `LSW_MODE_UNPOWERED;
  localparam logic [2:0] m_fs = `LSW_MODE_FAILSAFE;
  localparam logic [2:0] m_nrm = `LSW_MODE_NORMAL;
  localparam logic [2:0] m_sil = `LSW_MODE_SILENT;
  localparam logic [2:0] m_slp = `LSW_MODE_SLEEP;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic en_pin = 1'b0;
  logic host_txd = 1'b1;
  logic bus_dom = 1'b0;
  logic op = 1'b0;
  logic bat_uv = 1'b0;
  logic vcc_uv = 1'b1;
  logic ot = 1'b0;
  int miscompares = 0;
  int checks = 0;
  wire txd_in, txd_out, txd_oe, rxd_out, bus_in, prewake, host_reset_out_n;
  wire reg_on, trx_en, term_on, rx_en, drv_dom;
  wire [2:0] mode;

  always #50 sys_clk = ~sys_clk;

  lsw_mode_ctrl #(.RES_CYC(RC)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .en_pin(en_pin), .txd_in(txd_in),
    .txd_out(txd_out), .txd_oe(txd_oe), .rxd_out(rxd_out), .bus_in(bus_in),
    .bus_prewake_threshold(prewake), .battery_supply_op(op), .battery_supply_uv(bat_uv),
    .vcc_uv(vcc_uv), .regulator_overtemp_limit(ot), .host_reset_out_n(host_reset_out_n),
    .regulator_on(reg_on), .transceiver_en(trx_en), .termination_on(term_on),
    .bus_rx_en(rx_en), .bus_drive_dom(drv_dom), .mode_out(mode)
  );
  lsw_host_model u_host (
    .host_txd(host_txd), .bus_dom(bus_dom), .txd_out(txd_out), .txd_oe(txd_oe),
    .txd_in(txd_in), .bus_in(bus_in), .bus_prewake_threshold(prewake)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Dominant for n cycles, then recessive long enough to settle
  task automatic bus_pulse(input int n);
    bus_dom = 1'b1;
    cyc(n);
    bus_dom = 1'b0;
    cyc(8);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_up;
    op = 1'b1;
    cyc(8);
    chk("mode", mode, m_fs);
    chk("reset", host_reset_out_n, 3'h0);
    en_pin = 1'b1;
    vcc_uv = 1'b0;
    cyc(RC - 4);
    chk("reset", host_reset_out_n, 3'h0);
    chk("mode", mode, m_fs);
    cyc(16);
    chk("mode", mode, m_nrm);
    chk("reset", host_reset_out_n, 3'h1);
    chk("transceiver", trx_en, 3'h1);
  endtask
  task automatic t_sleep;
    host_txd = 1'b0;
    cyc(6);
    chk("drive_dom", drv_dom, 3'h1);
    en_pin = 1'b0;
    cyc(10);
    chk("mode", mode, m_slp);
    chk("regulator", reg_on, 3'h0);
    chk("reset", host_reset_out_n, 3'h0);
    chk("rxd", rxd_out, 3'h0);
    bat_uv = 1'b1;
    bus_pulse(1100);
    chk("mode", mode, m_slp);
    bat_uv = 1'b0;
    cyc(6);
    bus_dom = 1'b1;
    cyc(10);
    chk("rx_en", rx_en, 3'h1);
    cyc(490);
    bus_dom = 1'b0;
    cyc(8);
    chk("mode", mode, m_slp);
    bus_pulse(1100);
    chk("mode", mode, m_fs);
    chk("regulator", reg_on, 3'h1);
    chk("termination", term_on, 3'h1);
    chk("txd_oe", txd_oe, 3'h1);
    chk("txd", txd_out, 3'h0);
    chk("rxd", rxd_out, 3'h0);
    host_txd = 1'b1;
    en_pin = 1'b1;
    cyc(RC + 16);
    chk("mode", mode, m_nrm);
    chk("txd_oe", txd_oe, 3'h0);
  endtask
  task automatic t_silent;
    en_pin = 1'b0;
    cyc(10);
    chk("mode", mode, m_sil);
    chk("regulator", reg_on, 3'h1);
    chk("rxd", rxd_out, 3'h1);
    host_txd = 1'b0;
    cyc(6);
    bus_pulse(1100);
    chk("mode", mode, m_sil);
    host_txd = 1'b1;
    cyc(6);
    bus_pulse(1100);
    chk("mode", mode, m_fs);
    chk("regulator", reg_on, 3'h1);
    chk("termination", term_on, 3'h1);
    en_pin = 1'b1;
    cyc(8);
    chk("mode", mode, m_nrm);
    en_pin = 1'b0;
    cyc(10);
    en_pin = 1'b1;
    cyc(10);
    chk("mode", mode, m_nrm);
  endtask
  task automatic t_undervoltage;
    bat_uv = 1'b1;
    cyc(8);
    chk("mode", mode, m_fs);
    chk("transceiver", trx_en, 3'h0);
    chk("regulator", reg_on, 3'h1);
    chk("txd", txd_out, 3'h1);
    chk("rxd", rxd_out, 3'h0);
    en_pin = 1'b0;
    cyc(10);
    chk("mode", mode, m_sil);
    bat_uv = 1'b0;
    vcc_uv = 1'b1;
    cyc(8);
    chk("mode", mode, m_fs);
    chk("reset", host_reset_out_n, 3'h0);
    vcc_uv = 1'b0;
    en_pin = 1'b1;
    cyc(RC + 16);
    chk("mode", mode, m_nrm);
  endtask
  task automatic t_overtemp;
    ot = 1'b1;
    cyc(8);
    chk("regulator", reg_on, 3'h0);
    ot = 1'b0;
    cyc(8);
    chk("regulator", reg_on, 3'h1);
  endtask
  task automatic t_supply_loss;
    host_txd = 1'b0;
    cyc(6);
    en_pin = 1'b0;
    cyc(10);
    op = 1'b0;
    cyc(8);
    chk("mode", mode, m_unp);
  endtask

  initial
  begin
    #2000000;
    miscompares++;
    finish_test();
  end
  initial
  begin
    cyc(8);
    resetn = 1'b1;
    cyc(4);
    t_power_up();
    t_sleep();
    t_silent();
    t_undervoltage();
    t_overtemp();
    t_supply_loss();
    finish_test();
  end
endmodule // test_lsw_mode_ctrl
